// >>> hw/cc_access_pkg.sv
package cc_access_pkg;
   // Condition byte bit positions
   localparam int BIT_CC_HIGH = 7;
   localparam int BIT_CC_LOW = 6;
   localparam int BIT_ARITH = 5;
   localparam int BIT_STICKY = 4;
   localparam int BIT_ALT_BRANCH = 3;
   localparam int BIT_SIGNAL = 2;
   localparam int BIT_LOGIC = 1;
   localparam int BIT_FIRST_SCAN = 0;
   localparam int FLAG_W = 8;
   localparam int ACC_W = 32;
   // Selector codes
   localparam logic [15:0] SEL_LOAD = 16'h0001;
   localparam logic [15:0] SEL_SET = 16'h0002;
   localparam logic [15:0] SEL_CLEAR = 16'h0003;
   // Error identifier and reset values
   localparam logic [15:0] ERR_ID = 16'h1A49;
   localparam logic [7:0] FLAGS_RST = 8'h00;
   localparam logic [31:0] ACC_RST = 32'h00000000;
endpackage : cc_access_pkg

// >>> hw/condition_code_access_unit.sv
// What this block does
// - Bits 7 to 0 hold cc high, cc low, ovf, sticky ovf, alt branch, signal, logic, first scan.
// - The selector is the low word of accumulator two and only 1, 2 and 3 are valid.
// - Selector 1 copies accumulator one into the flag byte.
// - Selector 2 sets masked bits, selector 3 clears masked bits, other bits are kept.
// - After a set or clear the resulting flag byte is written back into accumulator one.
// - Every error-free access forces alternate branch to 0, signal level to 1 and first scan to 0.
// - A selector other than 1, 2 or 3 raises a runtime error.
// - Any set bit among 8 to 31 of accumulator one raises a runtime error.
// - On error, 1A49H goes to the low word of accumulator one and the handler is called.
// - Without an installed handler the unit enters the halted stop state.
// - With i_ce high, not halted and no flag byte access in the same cycle, the clear command zeroes all four accumulators and never errors.
`timescale 1ns/1ps
module condition_code_access_unit (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   // Commands from the sequencer
   input wire logic i_flag_byte_access_cmd,
   input wire logic i_accumulator_clear_cmd,
   input wire logic i_handler_installed,
   input wire logic i_halt_release,
   // Accumulator load port
   input wire logic i_acc_wr,
   input wire logic [1:0] i_acc_sel,
   input wire logic [cc_access_pkg::ACC_W-1:0] i_acc_wdata,
   // Accumulators and flags
   output logic [cc_access_pkg::ACC_W-1:0] o_accumulator_one,
   output logic [cc_access_pkg::ACC_W-1:0] o_accumulator_two,
   output logic [cc_access_pkg::ACC_W-1:0] o_accumulator_three,
   output logic [cc_access_pkg::ACC_W-1:0] o_accumulator_four,
   output logic [cc_access_pkg::FLAG_W-1:0] o_condition_flags,
   // Error reporting
   output logic o_runtime_error_handler,
   output logic o_halted
);
   import cc_access_pkg::*;

   logic [ACC_W-1:0] acc_q [4];
   logic [FLAG_W-1:0] flags_q;
   logic err_call_q;
   logic halted_q;

   wire [15:0] acc_two_low_word = acc_q[1][15:0];
   wire [FLAG_W-1:0] operand = acc_q[0][FLAG_W-1:0];
   wire sel_ok = (acc_two_low_word == SEL_LOAD) || (acc_two_low_word == SEL_SET)
      || (acc_two_low_word == SEL_CLEAR);
   wire high_set = |acc_q[0][ACC_W-1:FLAG_W];
   wire op_err = !sel_ok || high_set;
   wire run = i_ce && !halted_q;
   wire do_access = run && i_flag_byte_access_cmd;
   wire do_clear = run && i_accumulator_clear_cmd && !i_flag_byte_access_cmd;
   wire [FLAG_W-1:0] raw_flags =
      (acc_two_low_word == SEL_LOAD) ? operand :
      (acc_two_low_word == SEL_SET) ? (flags_q | operand) :
      (flags_q & ~operand);
   wire [FLAG_W-1:0] force_clr = FLAG_W'((1 << BIT_ALT_BRANCH) | (1 << BIT_FIRST_SCAN));
   wire [FLAG_W-1:0] force_set = FLAG_W'(1 << BIT_SIGNAL);
   wire [FLAG_W-1:0] new_flags = (raw_flags & ~force_clr) | force_set;
   wire write_back = (acc_two_low_word != SEL_LOAD);
   wire load_en = run && i_acc_wr && !i_flag_byte_access_cmd && !i_accumulator_clear_cmd;
   wire do_err = do_access && op_err;
   wire do_update = do_access && !op_err;
   wire halt_now = do_err && !i_handler_installed;
   wire call_now = do_err && i_handler_installed;

   // Accumulators, one per entry
   for (genvar k = 0; k < 4; k++) begin : g_acc
      wire load_here = load_en && (i_acc_sel == 2'(k));
      wire is_first = (k == 0);
      always_ff @(posedge i_clk) begin
         if (!i_rst_n) begin
            acc_q[k] <= ACC_RST;
         end else if (do_err && is_first) begin
            acc_q[k][15:0] <= ERR_ID;
         end else if (do_update && write_back && is_first) begin
            acc_q[k] <= {{(ACC_W-FLAG_W){1'b0}}, new_flags};
         end else if (do_clear) begin
            acc_q[k] <= ACC_RST;
         end else if (load_here) begin
            acc_q[k] <= i_acc_wdata;
         end
      end
   end : g_acc

   // Flag byte, kept on error
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         flags_q <= FLAGS_RST;
      end else if (do_access && !op_err) begin
         flags_q <= new_flags;
      end
   end

   // Handler call pulse
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         err_call_q <= 1'b0;
      end else if (i_ce) begin
         err_call_q <= call_now;
      end
   end

   // Stop state
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         halted_q <= 1'b0;
      end else if (halt_now) begin
         halted_q <= 1'b1;
      end else if (i_ce && i_halt_release) begin
         halted_q <= 1'b0;
      end
   end

   assign o_accumulator_one = acc_q[0];
   assign o_accumulator_two = acc_q[1];
   assign o_accumulator_three = acc_q[2];
   assign o_accumulator_four = acc_q[3];
   assign o_condition_flags = flags_q;
   assign o_runtime_error_handler = err_call_q;
   assign o_halted = halted_q;

   property p_forced_bits;
      @(posedge i_clk) disable iff (!i_rst_n)
      (do_access && !op_err) |=> (flags_q[BIT_SIGNAL] && !flags_q[BIT_ALT_BRANCH]
         && !flags_q[BIT_FIRST_SCAN]);
   endproperty
   a_forced_bits: assert property (p_forced_bits) else $error("forced bits wrong");

   property p_err_id;
      @(posedge i_clk) disable iff (!i_rst_n)
      (do_access && op_err) |=> (acc_q[0][15:0] == ERR_ID && $stable(flags_q));
   endproperty
   a_err_id: assert property (p_err_id) else $error("error id missing");

   property p_halt;
      @(posedge i_clk) disable iff (!i_rst_n)
      (do_access && op_err && !i_handler_installed) |=> halted_q;
   endproperty
   a_halt: assert property (p_halt) else $error("no halt");

   property p_clear;
      @(posedge i_clk) disable iff (!i_rst_n)
      do_clear |=> (acc_q[0] == ACC_RST && acc_q[3] == ACC_RST && !err_call_q);
   endproperty
   a_clear: assert property (p_clear) else $error("clear failed");

   property p_write_back;
      @(posedge i_clk) disable iff (!i_rst_n)
      (do_access && !op_err && write_back) |=> (acc_q[0] == {24'h000000, flags_q});
   endproperty
   a_write_back: assert property (p_write_back) else $error("no write back");

   property p_sel_err;
      @(posedge i_clk) disable iff (!i_rst_n)
      (do_access && !sel_ok && i_handler_installed)
         |=> (err_call_q && acc_q[0][15:0] == ERR_ID);
   endproperty
   a_sel_err: assert property (p_sel_err) else $error("bad selector not flagged");

   property p_rsv_halt;
      @(posedge i_clk) disable iff (!i_rst_n)
      (do_access && sel_ok && high_set && !i_handler_installed)
         |=> (halted_q && !err_call_q);
   endproperty
   a_rsv_halt: assert property (p_rsv_halt) else $error("reserved bits missed");

   property p_load_flags;
      @(posedge i_clk) disable iff (!i_rst_n)
      (do_update && acc_two_low_word == SEL_LOAD)
         |=> (flags_q[BIT_CC_HIGH:BIT_STICKY] == $past(operand[BIT_CC_HIGH:BIT_STICKY])
         && flags_q[BIT_LOGIC] == $past(operand[BIT_LOGIC]));
   endproperty
   a_load_flags: assert property (p_load_flags) else $error("load lost bits");

   property p_load_keeps;
      @(posedge i_clk) disable iff (!i_rst_n)
      (do_update && acc_two_low_word == SEL_LOAD)
         |=> $stable(acc_q[0]);
   endproperty
   a_load_keeps: assert property (p_load_keeps) else $error("load changed acc one");

   property p_set_mask;
      @(posedge i_clk) disable iff (!i_rst_n)
      (do_update && acc_two_low_word == SEL_SET)
         |=> (flags_q[BIT_CC_HIGH:BIT_STICKY] == ($past(flags_q[BIT_CC_HIGH:BIT_STICKY])
         | $past(operand[BIT_CC_HIGH:BIT_STICKY])));
   endproperty
   a_set_mask: assert property (p_set_mask) else $error("set mask wrong");

   property p_clr_mask;
      @(posedge i_clk) disable iff (!i_rst_n)
      (do_update && acc_two_low_word == SEL_CLEAR)
         |=> (flags_q[BIT_CC_HIGH:BIT_STICKY] == ($past(flags_q[BIT_CC_HIGH:BIT_STICKY])
         & ~$past(operand[BIT_CC_HIGH:BIT_STICKY])));
   endproperty
   a_clr_mask: assert property (p_clr_mask) else $error("clear mask wrong");

   property p_err_high;
      @(posedge i_clk) disable iff (!i_rst_n)
      do_err
         |=> (acc_q[0][ACC_W-1:16] == $past(acc_q[0][ACC_W-1:16]));
   endproperty
   a_err_high: assert property (p_err_high) else $error("upper word changed");

   property p_good_quiet;
      @(posedge i_clk) disable iff (!i_rst_n)
      do_update
         |=> (!err_call_q && !halted_q);
   endproperty
   a_good_quiet: assert property (p_good_quiet) else $error("valid access flagged");

   property p_halt_holds;
      @(posedge i_clk) disable iff (!i_rst_n)
      (halted_q && !i_halt_release)
         |=> (halted_q && $stable(flags_q) && $stable(acc_q[0]));
   endproperty
   a_halt_holds: assert property (p_halt_holds) else $error("halt not held");

   property p_clear_rest;
      @(posedge i_clk) disable iff (!i_rst_n)
      do_clear
         |=> (acc_q[1] == ACC_RST && acc_q[2] == ACC_RST && $stable(flags_q));
   endproperty
   a_clear_rest: assert property (p_clear_rest) else $error("clear incomplete");
endmodule : condition_code_access_unit

// >>> tb/seq_model.sv
`timescale 1ns/1ps
module seq_model (
   // Clock
   input wire logic i_clk,
   // Requests to the unit
   output logic o_fa,
   output logic o_clr,
   output logic o_wr,
   output logic [1:0] o_sel,
   output logic [31:0] o_wd
);
   initial begin
      {o_fa, o_clr, o_wr, o_sel, o_wd} = '0;
   end
   // Operand, selector, then one command
   task automatic call(input logic [31:0] op, input logic [31:0] fn, input logic clr);
      @(posedge i_clk) {o_wr, o_sel, o_wd} <= {3'b100, op};
      @(posedge i_clk) {o_sel, o_wd} <= {2'b01, fn};
      @(posedge i_clk) {o_wr, o_fa, o_clr, o_wd} <= {1'b0, ~clr, clr, ~o_wd};
      @(posedge i_clk) {o_fa, o_clr} <= 2'b00;
   endtask : call
   // Plain accumulator load
   task automatic load(input logic [1:0] s, input logic [31:0] v);
      @(posedge i_clk) {o_wr, o_sel, o_wd} <= {1'b1, s, v};
      @(posedge i_clk) o_wr <= 1'b0;
   endtask : load
endmodule : seq_model

// >>> tb/tb_condition_code_access_unit.sv
`timescale 1ns/1ps
module tb_condition_code_access_unit;
   import cc_access_pkg::*;
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic hnd = 1'b1;
   logic rel = 1'b0;
   logic ce = 1'b1;
   logic fa, clr, wr, err, hlt;
   logic [1:0] sel;
   logic [31:0] wd, a1, a2, a3, a4;
   logic [7:0] fl;
   int n_fail = 0;
   int tests_run = 0;
   int cyc = 0;
   initial begin
      forever #2.5 i_clk = ~i_clk;
   end
   seq_model i_seq (.i_clk(i_clk), .o_fa(fa), .o_clr(clr), .o_wr(wr), .o_sel(sel), .o_wd(wd));
   condition_code_access_unit i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(ce),
      .i_flag_byte_access_cmd(fa), .i_accumulator_clear_cmd(clr), .i_handler_installed(hnd),
      .i_halt_release(rel), .i_acc_wr(wr), .i_acc_sel(sel), .i_acc_wdata(wd),
      .o_accumulator_one(a1), .o_accumulator_two(a2), .o_accumulator_three(a3),
      .o_accumulator_four(a4), .o_condition_flags(fl), .o_runtime_error_handler(err),
      .o_halted(hlt));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      tests_run++;
      if (s !== e) begin
         n_fail++;
         $display("unexpected %s exp %h got %h", nm, e, s);
      end
   endtask : chk
   task automatic give_verdict;
      if (n_fail == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : give_verdict
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         n_fail++;
         give_verdict();
      end
   end
   initial begin
      repeat (12) @(posedge i_clk);
      i_rst_n <= 1'b1;
      #1 chk("flags", {24'h0, FLAGS_RST}, fl);
      i_seq.call(32'hFF, 32'h1, 1'b0);
      #1 chk("flags", 32'hF6, fl);
      chk("acc1", 32'hFF, a1);
      chk("acc2", 32'h1, a2);
      i_seq.call(32'hC0, 32'h3, 1'b0);
      #1 chk("flags", 32'h36, fl);
      chk("acc1", 32'h36, a1);
      i_seq.call(32'h89, 32'h2, 1'b0);
      #1 chk("flags", 32'hB6, fl);
      chk("acc1", 32'hB6, a1);
      i_seq.call(32'h12, 32'h4, 1'b0);
      #1 chk("acc1", {16'h0, ERR_ID}, a1);
      chk("pulse", 32'h1, err);
      chk("flags", 32'hB6, fl);
      @(posedge i_clk) hnd <= 1'b0;
      i_seq.call(32'h10000, 32'h1, 1'b0);
      #1 chk("halt", 32'h1, hlt);
      chk("acc1", {16'h1, ERR_ID}, a1);
      chk("pulse", 32'h0, err);
      i_seq.call(32'h5, 32'h1, 1'b0);
      #1 chk("flags", 32'hB6, fl);
      chk("acc1", {16'h1, ERR_ID}, a1);
      @(posedge i_clk) {hnd, rel} <= 2'b11;
      @(posedge i_clk) rel <= 1'b0;
      #1 chk("halt", 32'h0, hlt);
      @(posedge i_clk) ce <= 1'b0;
      i_seq.call(32'h40, 32'h2, 1'b0);
      #1 chk("flags", 32'hB6, fl);
      chk("acc1", {16'h1, ERR_ID}, a1);
      @(posedge i_clk) ce <= 1'b1;
      i_seq.load(2'h2, 32'hA5A5A5A5);
      i_seq.load(2'h3, 32'h5A5A5A5A);
      #1 chk("acc3", 32'hA5A5A5A5, a3);
      chk("acc4", 32'h5A5A5A5A, a4);
      i_seq.call(32'hFFFFFFFF, 32'h5, 1'b1);
      #1 chk("accs", 32'h0, a1 | a2 | a3 | a4);
      chk("err", 32'h0, {err, hlt});
      chk("flags", 32'hB6, fl);
      @(posedge i_clk) i_rst_n <= 1'b0;
      repeat (2) @(posedge i_clk);
      i_rst_n <= 1'b1;
      #1 chk("flags", {24'h0, FLAGS_RST}, fl);
      i_seq.call(32'h0, 32'h1, 1'b0);
      #1 chk("flags", 32'h04, fl);
      give_verdict();
   end
endmodule : tb_condition_code_access_unit
